// [src/pmw_pkg.sv]
`default_nettype none
package pmw_pkg;
  // ****************************
  // Register map
  // ****************************
  localparam logic [3:0] PMW_OFS_CTRL1 = 4'h0;
  localparam logic [3:0] PMW_OFS_CTRL2 = 4'h4;
  localparam logic [3:0] PMW_OFS_STAT  = 4'h8;
  localparam logic [7:0] PMW_CTRL1_RST = 8'h03;
  localparam logic [7:0] PMW_CTRL2_RST = 8'h00;
  localparam logic [7:0] PMW_CTRL1_WM  = 8'hF3;
  localparam logic [7:0] PMW_CTRL2_WM  = 8'h87;
  localparam int PMW_B_DIV_LO = 5;
  localparam int PMW_B_FAST   = 4;
  localparam int PMW_B_LSRDY  = 3;
  localparam int PMW_B_HSRDY  = 2;
  localparam int PMW_B_IDLE_EN = 1;
  localparam int PMW_B_HSEL   = 0;
  localparam int PMW_B_KEEP   = 7;
  localparam int PMW_B_LV_FLAG = 2;
  localparam int PMW_B_BADV   = 1;
  localparam int PMW_B_WDCR   = 0;
  localparam logic [2:0] PMW_DIV_LS0 = 3'h0;
  localparam logic [2:0] PMW_DIV_LS1 = 3'h1;
  localparam logic [1:0] PMW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PMW_RESP_SLVERR = 2'h2;
  // ****************************
  // Oscillator timing, in cycles
  // ****************************
  localparam logic [10:0] PMW_HS_XTAL_SETTLE = 11'h400;
  localparam logic [10:0] PMW_RC_OSC_SETTLE  = 11'h010;
  localparam logic [10:0] PMW_LS_XTAL_SETTLE = 11'h400;
  localparam logic [1:0]  PMW_WAKE_TICKS  = 2'h2;
  // ****************************
  // Types
  // ****************************
  typedef enum logic [2:0] {
    PMW_RUN       = 3'h0,
    PMW_SLEEP1    = 3'h1,
    PMW_IDLE0     = 3'h2,
    PMW_IDLE1     = 3'h3,
    PMW_WAKE_TICK = 3'h4,
    PMW_WAKE_FAST = 3'h5,
    PMW_WAKE_HS   = 3'h6
  } pmw_state_t;
  typedef enum logic [1:0] {
    PMW_SRC_HS   = 2'h0,
    PMW_SRC_HDIV = 2'h1,
    PMW_SRC_LS   = 2'h2
  } pmw_src_t;
endpackage : pmw_pkg
`default_nettype wire

// [src/pmw_clk_switch.sv]
`timescale 1ns/1ps
`default_nettype none
module pmw_clk_switch
  import pmw_pkg::*;
(
  input  wire logic     aclk,       // Clock
  input  wire logic     aresetn,    // Sync reset, low
  input  wire pmw_src_t src_req,    // Wanted source
  input  wire logic     cpu_req,    // Core clock wanted
  input  wire logic     sys_req,    // System clock wanted
  output pmw_src_t      src_q,      // Source in use
  output logic          cpu_en_q,   // Core clock gate
  output logic          sys_en_q    // System clock gate
);
  // Source only moves while both gates are closed
  wire logic change = (src_req != src_q);
  wire logic closed = !cpu_en_q && !sys_en_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q    <= PMW_SRC_HS;
      cpu_en_q <= 1'b0;
      sys_en_q <= 1'b0;
    end else begin
      if (change && closed)
        src_q <= src_req;
      cpu_en_q <= cpu_req && !change;
      sys_en_q <= sys_req && !change;
    end
  end

  // ****************************
  // Assertions
  // ****************************
  property p_src_quiet;
    @(posedge aclk) disable iff (!aresetn)
      src_q != $past(src_q) |-> !cpu_en_q && !sys_en_q &&
                                !$past(cpu_en_q) && !$past(sys_en_q);
  endproperty
  a_src_quiet: assert property (p_src_quiet) else $error("live switch");
endmodule : pmw_clk_switch
`default_nettype wire

// [src/pmw_ctrl.sv]
// What this block does
// - Control-two bit 7 keeps system clock in idle when set.
// - Low-voltage reset sets flag bit 2; only software clears it.
// - Bad voltage code sets bit 1, acts as software reset.
// - Watchdog-control software reset sets bit 0; software clears.
// - Control-two bits 6 to 3 read as zero.
// - Fast wake only from sleep1 or idle0, never sleep0.
// - Crystal fast wake: 1-2 slow cycles, slow clock until 1024 cycles.
// - RC oscillator wakes in 15-16 RC cycles regardless of fast wake.
// - Low-speed ready flag shows slow crystal stable; software checks.
// - Halt picks idle or sleep from idle enable and keep bit.
// - Slow clock selected stops the high-speed oscillator.
// - Sleep0 is never entered; watchdog keeps slow clock on.
// - Halt with idle enable 0 enters sleep1.
// - Halt with idle enable 1, keep 0 enters idle0.
// - Halt with idle enable 1, keep 1 enters idle1.
// - Entry holds state, clears watchdog, sets power-down, clears timeout.
// - Idle enable 1 gives idle, 0 gives sleep.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module pmw_ctrl
  import pmw_pkg::*;
#(
  parameter bit HS_IS_RC = 1'b0     // High-speed source is RC
)(
  input  wire logic        aclk,          // 25 MHz clock
  input  wire logic        aresetn,       // Sync reset, low
  input  wire logic [3:0]  s_awaddr,      // AXI write address
  input  wire logic        s_awvalid,     // AXI
  output logic             s_awready,     // AXI
  input  wire logic [31:0] s_wdata,       // AXI write data
  input  wire logic [3:0]  s_wstrb,       // AXI
  input  wire logic        s_wvalid,      // AXI
  output logic             s_wready,      // AXI
  output logic [1:0]       s_bresp,       // AXI
  output logic             s_bvalid,      // AXI
  input  wire logic        s_bready,      // AXI
  input  wire logic [3:0]  s_araddr,      // AXI read address
  input  wire logic        s_arvalid,     // AXI
  output logic             s_arready,     // AXI
  output logic [31:0]      s_rdata,       // AXI
  output logic [1:0]       s_rresp,       // AXI
  output logic             s_rvalid,      // AXI
  input  wire logic        s_rready,      // AXI
  input  wire logic        hs_tick,       // High-speed osc cycle
  input  wire logic        ls_tick,       // Low-speed clock cycle
  input  wire logic        halt_req,      // Power-down instruction
  input  wire logic        wake_req,      // Wake-up source
  input  wire logic        wdt_timeout,   // Watchdog time-out
  input  wire logic        clr_wdt_cmd,   // Clear-watchdog instr
  input  wire logic        lvr_event,     // Low-voltage reset
  input  wire logic        lvr_code_bad,  // Undefined voltage code
  input  wire logic        wdt_ctrl_rst,  // Watchdog-control reset
  output logic             hs_osc_en_q,   // High-speed osc enable
  output logic             cpu_clk_en,    // Core clock gate
  output logic             sys_clk_en,    // System clock gate
  output pmw_src_t         clk_src,       // Clock source in use
  output logic [2:0]       clk_div_q,     // Divider for HDIV
  output logic             soft_reset_q,  // Software reset pulse
  output logic             wdt_clear_q,   // Watchdog clear pulse
  output logic             power_down_flag_q, // Power-down flag
  output logic             timeout_flag_q     // Time-out flag
);
  // ****************************
  // Bus slave
  // ****************************
  logic [3:0]  awaddr_q;
  logic        aw_have_q, w_have_q, wstrb0_q;
  logic [7:0]  wdata_q;
  logic [7:0]  ctrl1_q, ctrl2_q, ctrl1_d, ctrl2_d;
  logic [10:0] hs_cnt_q, ls_cnt_q;
  logic        hs_ready_q, ls_ready_q, bad_q;
  logic [1:0]  wake_cnt_q;
  logic        wake_ls_q, wake_fast_q;
  pmw_state_t  state_q, state_d;

  function automatic logic [1:0] reg_sel(input logic [3:0] a);
    unique case (a)
      PMW_OFS_CTRL1: reg_sel = 2'h1;
      PMW_OFS_CTRL2: reg_sel = 2'h2;
      PMW_OFS_STAT:  reg_sel = 2'h3;
      default:       reg_sel = 2'h0;
    endcase
  endfunction : reg_sel

  wire logic       aw_fire = s_awvalid && s_awready;
  wire logic       w_fire  = s_wvalid && s_wready;
  wire logic       ar_fire = s_arvalid && s_arready;
  wire logic       wr_do   = aw_have_q && w_have_q && !s_bvalid;
  wire logic [1:0] wsel    = reg_sel(awaddr_q);
  wire logic [1:0] rsel    = reg_sel(s_araddr);
  wire logic       wr_c1   = wr_do && wstrb0_q && (wsel == 2'h1);
  wire logic       wr_c2   = wr_do && wstrb0_q && (wsel == 2'h2);

  wire logic [7:0] ctrl1_rd = {ctrl1_q[7:4], ls_ready_q, hs_ready_q,
                               ctrl1_q[1:0]};
  wire logic [7:0] ctrl2_rd = ctrl2_q & PMW_CTRL2_WM;
  wire logic [7:0] stat_rd  = {cpu_clk_en, clk_src, timeout_flag_q,
                               power_down_flag_q, state_q};
  wire logic [7:0] rd_byte  = (rsel == 2'h1) ? ctrl1_rd :
                              (rsel == 2'h2) ? ctrl2_rd :
                              (rsel == 2'h3) ? stat_rd : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= PMW_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_wdata[7:0];
        wstrb0_q <= s_wstrb[0];
        s_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (wsel == 2'h0) ? PMW_RESP_SLVERR : PMW_RESP_OKAY;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= PMW_RESP_OKAY;
    end else if (ar_fire) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rdata   <= {24'h0, rd_byte};
      s_rresp   <= (rsel == 2'h0) ? PMW_RESP_SLVERR : PMW_RESP_OKAY;
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ****************************
  // Control registers and flags
  // ****************************
  wire logic       bad_rise = lvr_code_bad && !bad_q;
  wire logic [2:0] flag_set = {lvr_event, bad_rise, wdt_ctrl_rst};

  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    ctrl1_d = wr_c1 ? (wdata_q & PMW_CTRL1_WM) : ctrl1_q;
    ctrl2_d = wr_c2 ? (wdata_q & PMW_CTRL2_WM) : ctrl2_q;
    ctrl2_d[2:0] = ctrl2_d[2:0] | flag_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q      <= PMW_CTRL1_RST;
      ctrl2_q      <= PMW_CTRL2_RST;
      bad_q        <= 1'b0;
      soft_reset_q <= 1'b0;
      clk_div_q    <= PMW_DIV_LS0;
    end else begin
      ctrl1_q      <= ctrl1_d;
      ctrl2_q      <= ctrl2_d;
      bad_q        <= lvr_code_bad;
      soft_reset_q <= bad_rise;
      clk_div_q    <= ctrl1_q[7:PMW_B_DIV_LO];
    end
  end

  wire logic [2:0] div     = ctrl1_q[7:PMW_B_DIV_LO];
  wire logic       hsel    = ctrl1_q[PMW_B_HSEL];
  wire logic       idle_en = ctrl1_q[PMW_B_IDLE_EN];
  wire logic       fast_en = ctrl1_q[PMW_B_FAST];
  wire logic       keep    = ctrl2_q[PMW_B_KEEP];
  // Slow mode is what software selects; the block only obeys
  wire logic sel_ls = !hsel && (div == PMW_DIV_LS0 || div == PMW_DIV_LS1);

  // ****************************
  // Oscillator readiness
  // ****************************
  wire logic [10:0] hs_settle = HS_IS_RC ? PMW_RC_OSC_SETTLE :
                                           PMW_HS_XTAL_SETTLE;
  wire logic osc_stop = (state_q == PMW_SLEEP1) || (state_q == PMW_IDLE0);
  wire logic hs_en_d  = !sel_ls && !osc_stop;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_osc_en_q <= 1'b0;
      hs_cnt_q    <= 11'h0;
      hs_ready_q  <= 1'b0;
      ls_cnt_q    <= 11'h0;
      ls_ready_q  <= 1'b0;
    end else begin
      hs_osc_en_q <= hs_en_d;
      if (!hs_osc_en_q) begin
        hs_cnt_q   <= 11'h0;
        hs_ready_q <= 1'b0;
      end else if (hs_cnt_q == hs_settle) begin
        hs_ready_q <= 1'b1;
      end else if (hs_tick) begin
        hs_cnt_q <= hs_cnt_q + 11'h1;
      end
      // Watchdog keeps the slow crystal on, so readiness never drops
      if (ls_cnt_q == PMW_LS_XTAL_SETTLE)
        ls_ready_q <= 1'b1;
      else if (ls_tick)
        ls_cnt_q <= ls_cnt_q + 11'h1;
    end
  end

  // ****************************
  // Power mode sequencer
  // ****************************
  wire logic wake     = wake_req || wdt_timeout;
  wire logic tick_sel = wake_ls_q ? ls_tick : hs_tick;
  wire logic enter    = (state_q == PMW_RUN) && halt_req;
  wire logic tick_end = tick_sel && (wake_cnt_q == PMW_WAKE_TICKS - 2'h1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PMW_RUN:
        if (halt_req)
          state_d = !idle_en ? PMW_SLEEP1 :
                    keep ? PMW_IDLE1 : PMW_IDLE0;
      PMW_SLEEP1, PMW_IDLE0:
        if (wake)
          state_d = (sel_ls || (fast_en && !HS_IS_RC)) ?
                    PMW_WAKE_TICK : PMW_WAKE_HS;
      PMW_IDLE1:
        if (wake)
          state_d = PMW_WAKE_TICK;
      PMW_WAKE_TICK:
        if (tick_end)
          state_d = wake_fast_q ? PMW_WAKE_FAST : PMW_RUN;
      PMW_WAKE_FAST, PMW_WAKE_HS:
        if (hs_ready_q)
          state_d = PMW_RUN;
      default: state_d = PMW_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= PMW_RUN;
      wake_cnt_q  <= 2'h0;
      wake_ls_q   <= 1'b0;
      wake_fast_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q != PMW_WAKE_TICK) begin
        wake_cnt_q  <= 2'h0;
        wake_ls_q   <= sel_ls || (state_q != PMW_IDLE1);
        wake_fast_q <= !sel_ls && (state_q != PMW_IDLE1);
      end else if (tick_sel) begin
        wake_cnt_q <= wake_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_down_flag_q <= 1'b0;
      timeout_flag_q    <= 1'b0;
      wdt_clear_q       <= 1'b0;
    end else begin
      wdt_clear_q <= enter;
      if (enter)
        power_down_flag_q <= 1'b1;
      else if (clr_wdt_cmd)
        power_down_flag_q <= 1'b0;
      if (wdt_timeout)
        timeout_flag_q <= 1'b1;
      else if (enter || clr_wdt_cmd)
        timeout_flag_q <= 1'b0;
    end
  end

  // ****************************
  // Clock gating
  // ****************************
  // Before the fast crystal is ready the slow clock stands in
  wire logic      run_ls  = sel_ls || (state_q == PMW_WAKE_FAST) ||
                            !hs_ready_q;
  wire pmw_src_t  src_req = run_ls ? PMW_SRC_LS :
                            hsel ? PMW_SRC_HS : PMW_SRC_HDIV;
  wire logic      cpu_req = (state_q == PMW_RUN) ||
                            (state_q == PMW_WAKE_FAST);
  wire logic      sys_req = cpu_req || (state_q == PMW_IDLE1);

  pmw_clk_switch u_switch (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .src_req  (src_req),
    .cpu_req  (cpu_req),
    .sys_req  (sys_req),
    .src_q    (clk_src),
    .cpu_en_q (cpu_clk_en),
    .sys_en_q (sys_clk_en)
  );

  // ****************************
  // Assertions
  // ****************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sleep1;
    enter && !idle_en |=> state_q == PMW_SLEEP1;
  endproperty
  a_sleep1: assert property (p_sleep1) else $error("no sleep1");
  property p_idle0;
    enter && idle_en && !keep |=> state_q == PMW_IDLE0;
  endproperty
  a_idle0: assert property (p_idle0) else $error("no idle0");
  property p_idle1;
    enter && idle_en && keep |=> state_q == PMW_IDLE1 ##1 sys_clk_en;
  endproperty
  a_idle1: assert property (p_idle1) else $error("no idle1");
  property p_entry;
    enter |=> power_down_flag_q && wdt_clear_q &&
              (timeout_flag_q == $past(wdt_timeout));
  endproperty
  a_entry: assert property (p_entry) else $error("entry flags");
  property p_low_voltage_reset_flag;
    lvr_event |=> ctrl2_q[PMW_B_LV_FLAG];
  endproperty
  a_low_voltage_reset_flag: assert property (p_low_voltage_reset_flag) else $error("lvr flag");
  property p_badv;
    bad_rise |=> ctrl2_q[PMW_B_BADV] && soft_reset_q;
  endproperty
  a_badv: assert property (p_badv) else $error("bad code");
  property p_wdcr;
    wdt_ctrl_rst |=> ctrl2_q[PMW_B_WDCR];
  endproperty
  a_wdcr: assert property (p_wdcr) else $error("wdt ctrl flag");
  property p_rsvd;
    ar_fire && rsel == 2'h2 |=> s_rdata[6:3] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  property p_hs_off;
    sel_ls |=> !hs_osc_en_q;
  endproperty
  a_hs_off: assert property (p_hs_off) else $error("hs on");
  property p_idle0_gate;
    (state_q == PMW_IDLE0)[*3] |-> !sys_clk_en && !cpu_clk_en;
  endproperty
  a_idle0_gate: assert property (p_idle0_gate) else $error("gate");
  property p_fast_end;
    state_q == PMW_WAKE_FAST && hs_ready_q |=> state_q == PMW_RUN;
  endproperty
  a_fast_end: assert property (p_fast_end) else $error("fast");
  property p_rc_wake;
    osc_stop && wake && !sel_ls && (HS_IS_RC || !fast_en) |=>
      state_q == PMW_WAKE_HS;
  endproperty
  a_rc_wake: assert property (p_rc_wake) else $error("rc wake");

  c_fast: cover property (state_q == PMW_WAKE_FAST ##1 state_q == PMW_RUN);
  c_idle1: cover property (state_q == PMW_IDLE1 ##1 state_q != PMW_IDLE1);
  c_slow: cover property (clk_src == PMW_SRC_LS && cpu_clk_en);
endmodule : pmw_ctrl
`default_nettype wire

// [sim/pmw_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Oscillator and slow clock source
// ****************************
module pmw_osc_model #(
  parameter int HS_PER = 3,   // aclk cycles per fast osc cycle
  parameter int LS_PER = 16   // aclk cycles per slow cycle
)(
  input  wire logic aclk,     // Clock
  input  wire logic aresetn,  // Sync reset, low
  input  wire logic hs_en,    // Fast osc enable
  output logic      hs_tick,  // Fast osc cycle
  output logic      ls_tick   // Slow clock cycle
);
  int hs_cnt;
  int ls_cnt;

  // Stopped osc gives no ticks, restart counts from zero
  always @(posedge aclk) begin
    if (!aresetn || !hs_en) begin
      hs_cnt  <= 0;
      hs_tick <= 1'b0;
    end else begin
      hs_cnt  <= (hs_cnt == HS_PER - 1) ? 0 : hs_cnt + 1;
      hs_tick <= (hs_cnt == HS_PER - 1);
    end
  end

  // Watchdog always on, so slow clock never stops
  always @(posedge aclk) begin
    if (!aresetn) begin
      ls_cnt  <= 0;
      ls_tick <= 1'b0;
    end else begin
      ls_cnt  <= (ls_cnt == LS_PER - 1) ? 0 : ls_cnt + 1;
      ls_tick <= (ls_cnt == LS_PER - 1);
    end
  end
endmodule : pmw_osc_model
`default_nettype wire

// [sim/pmw_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pmw_ctrl_tb_top
  import pmw_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_awaddr, s_araddr, s_wstrb;
  logic [31:0] s_wdata, s_rdata;
  logic        s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bvalid, s_bready, s_arvalid, s_arready;
  logic        s_rvalid, s_rready;
  logic [1:0]  s_bresp, s_rresp;
  logic        hs_tick, ls_tick, halt_req, wake_req, wdt_timeout;
  logic        clr_wdt_cmd, lvr_event, lvr_code_bad, wdt_ctrl_rst;
  logic        hs_osc_en_q, cpu_clk_en, sys_clk_en, soft_reset_q;
  logic        wdt_clear_q, power_down_flag_q, timeout_flag_q;
  logic [2:0]  clk_div_q;
  pmw_src_t    clk_src;
  int          mismatches = 0;
  int          comparisons = 0;

  always #20 aclk = ~aclk;

  pmw_ctrl dut (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .hs_tick, .ls_tick, .halt_req, .wake_req, .wdt_timeout,
    .clr_wdt_cmd, .lvr_event, .lvr_code_bad, .wdt_ctrl_rst,
    .hs_osc_en_q, .cpu_clk_en, .sys_clk_en, .clk_src, .clk_div_q,
    .soft_reset_q, .wdt_clear_q, .power_down_flag_q, .timeout_flag_q
  );

  pmw_osc_model #(.HS_PER(3), .LS_PER(16)) osc (
    .aclk, .aresetn, .hs_en(hs_osc_en_q), .hs_tick, .ls_tick
  );

  // ****************************
  // Shared tasks
  // ****************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wcyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wcyc

  task automatic axw(input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr  <= a;
    s_wdata   <= {24'h000000, d};
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1 && n < 100);
    s_bready <= 1'b0;
    chk(s_bvalid, 1'b1, "bvalid");
    chk(s_bresp, er, "bresp");
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [7:0] d,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1 && n < 100);
    s_rready <= 1'b0;
    d = s_rdata[7:0];
    chk(s_rresp, er, "rresp");
    chk(s_rdata[31:8], 24'h000000, "rdata upper");
  endtask : axr

  // Core back on the fast clock before next step
  task automatic wait_run();
    int n;
    n = 0;
    while (!(cpu_clk_en === 1'b1 && clk_src === PMW_SRC_HS) && n < 20000)
    begin
      @(posedge aclk);
      n++;
    end
    chk(n < 20000, 1'b1, "core running");
    wcyc(4);
  endtask : wait_run

  task automatic poll(input int b);
    logic [7:0] v;
    int n;
    n = 0;
    do begin
      axr(PMW_OFS_CTRL1, v, PMW_RESP_OKAY);
      n++;
    end while (v[b] !== 1'b1 && n < 8000);
    chk(v[b], 1'b1, "ready flag");
  endtask : poll

  task automatic pulse_halt();
    @(posedge aclk) halt_req <= 1'b1;
    @(posedge aclk) halt_req <= 1'b0;
  endtask : pulse_halt

  task automatic pulse_wake();
    @(posedge aclk) wake_req <= 1'b1;
    @(posedge aclk) wake_req <= 1'b0;
  endtask : pulse_wake

  // ****************************
  // Scenarios
  // ****************************
  task automatic t_regs();
    logic [7:0] v;
    axr(PMW_OFS_CTRL1, v, PMW_RESP_OKAY);
    chk(v, PMW_CTRL1_RST, "ctrl1 reset");
    axr(PMW_OFS_CTRL2, v, PMW_RESP_OKAY);
    chk(v, PMW_CTRL2_RST, "ctrl2 reset");
    axr(4'hC, v, PMW_RESP_SLVERR);
    axw(4'hC, 8'hFF, PMW_RESP_SLVERR);
    axw(PMW_OFS_CTRL2, 8'hFF, PMW_RESP_OKAY);
    axr(PMW_OFS_CTRL2, v, PMW_RESP_OKAY);
    chk(v, 8'h87, "ctrl2 unused bits");
    s_wstrb <= 4'h0;
    axw(PMW_OFS_CTRL2, 8'h00, PMW_RESP_OKAY);
    s_wstrb <= 4'hF;
    axr(PMW_OFS_CTRL2, v, PMW_RESP_OKAY);
    chk(v, PMW_CTRL2_WM, "write without strobe");
    axw(PMW_OFS_CTRL2, 8'h00, PMW_RESP_OKAY);
    axr(PMW_OFS_CTRL2, v, PMW_RESP_OKAY);
    chk(v, 8'h00, "ctrl2 cleared");
    $display("test regs done");
  endtask : t_regs

  task automatic t_flags();
    logic [7:0] v;
    int n;
    @(posedge aclk) lvr_event <= 1'b1;
    @(posedge aclk) lvr_event <= 1'b0;
    axr(PMW_OFS_CTRL2, v, PMW_RESP_OKAY);
    chk(v, 8'h04, "low voltage flag");
    n = 0;
    @(posedge aclk) lvr_code_bad <= 1'b1;
    repeat (4) begin
      @(posedge aclk);
      n += (soft_reset_q === 1'b1);
    end
    chk(n, 1, "soft reset pulse");
    axr(PMW_OFS_CTRL2, v, PMW_RESP_OKAY);
    chk(v, 8'h06, "bad code flag");
    @(posedge aclk) wdt_ctrl_rst <= 1'b1;
    lvr_code_bad <= 1'b0;
    @(posedge aclk) wdt_ctrl_rst <= 1'b0;
    axr(PMW_OFS_CTRL2, v, PMW_RESP_OKAY);
    chk(v, 8'h07, "watchdog ctrl flag");
    axw(PMW_OFS_CTRL2, 8'h03, PMW_RESP_OKAY);
    axr(PMW_OFS_CTRL2, v, PMW_RESP_OKAY);
    chk(v, 8'h03, "sw clears one flag");
    axw(PMW_OFS_CTRL2, 8'h00, PMW_RESP_OKAY);
    axr(PMW_OFS_CTRL2, v, PMW_RESP_OKAY);
    chk(v, 8'h00, "sw clears all flags");
    $display("test flags done");
  endtask : t_flags

  task automatic t_halt(input logic idl, input logic keep,
                        input pmw_state_t st);
    logic [7:0] v;
    int n;
    wait_run();
    axw(PMW_OFS_CTRL1, {6'h00, idl, 1'b1}, PMW_RESP_OKAY);
    axw(PMW_OFS_CTRL2, {keep, 7'h00}, PMW_RESP_OKAY);
    @(posedge aclk) wdt_timeout <= 1'b1;
    @(posedge aclk) wdt_timeout <= 1'b0;
    wcyc(2);
    chk(timeout_flag_q, 1'b1, "timeout set");
    pulse_halt();
    n = 0;
    repeat (4) begin
      @(posedge aclk);
      n += (wdt_clear_q === 1'b1);
    end
    chk(n, 1, "watchdog clear pulse");
    chk(power_down_flag_q, 1'b1, "power-down flag");
    chk(timeout_flag_q, 1'b0, "timeout cleared");
    chk(cpu_clk_en, 1'b0, "core stopped");
    chk(sys_clk_en, st == PMW_IDLE1, "system clock");
    axr(PMW_OFS_STAT, v, PMW_RESP_OKAY);
    chk(v[2:0], st, "mode entered");
    pulse_wake();
    wait_run();
    @(posedge aclk) clr_wdt_cmd <= 1'b1;
    @(posedge aclk) clr_wdt_cmd <= 1'b0;
    wcyc(2);
    chk(power_down_flag_q, 1'b0, "power-down flag cleared");
    $display("test halt %0d%0d done", idl, keep);
  endtask : t_halt

  task automatic t_fast(input logic fast, input logic idl);
    int nl;
    int nh;
    wait_run();
    axw(PMW_OFS_CTRL2, 8'h00, PMW_RESP_OKAY);
    axw(PMW_OFS_CTRL1, {3'h0, fast, 2'h0, idl, 1'b1}, PMW_RESP_OKAY);
    pulse_halt();
    wcyc(4);
    pulse_wake();
    nl = 0;
    nh = 0;
    while (cpu_clk_en !== 1'b1 && nh < 5000) begin
      @(posedge aclk);
      nl += (ls_tick === 1'b1);
      nh += (hs_tick === 1'b1);
    end
    if (fast) begin
      chk(clk_src, PMW_SRC_LS, "fast wake on slow clock");
      chk(nl >= 1 && nl <= 2, 1'b1, "fast wake time");
    end else begin
      chk(nh >= 1024, 1'b1, "no early core clock");
    end
    while (clk_src !== PMW_SRC_HS && nh < 5000) begin
      @(posedge aclk);
      nh += (hs_tick === 1'b1);
    end
    chk(nh >= 1024 && nh <= 1030, 1'b1, "hand-over to crystal");
    $display("test fast wake %0d%0d done", fast, idl);
  endtask : t_fast

  task automatic t_slow();
    int d;
    wait_run();
    axw(PMW_OFS_CTRL1, 8'h01, PMW_RESP_OKAY);
    poll(PMW_B_LSRDY);
    for (d = 0; d < 8; d++) begin
      axw(PMW_OFS_CTRL1, {d[2:0], 5'h00}, PMW_RESP_OKAY);
      if (d >= 2) poll(PMW_B_HSRDY);
      wcyc(8);
      chk(clk_src, d < 2 ? PMW_SRC_LS : PMW_SRC_HDIV, "source");
      chk(hs_osc_en_q, d >= 2, "fast osc enable");
      chk(clk_div_q, d[2:0], "divider");
    end
    axw(PMW_OFS_CTRL1, 8'h01, PMW_RESP_OKAY);
    wait_run();
    $display("test slow mode done");
  endtask : t_slow

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  initial begin
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {halt_req, wake_req, wdt_timeout, clr_wdt_cmd} = '0;
    {lvr_event, lvr_code_bad, wdt_ctrl_rst} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    wait_run();
    t_flags();
    t_halt(1'b0, 1'b0, PMW_SLEEP1);
    t_halt(1'b1, 1'b0, PMW_IDLE0);
    t_halt(1'b1, 1'b1, PMW_IDLE1);
    t_halt(1'b0, 1'b1, PMW_SLEEP1);
    t_fast(1'b1, 1'b0);
    t_fast(1'b1, 1'b1);
    t_fast(1'b0, 1'b0);
    t_slow();
    final_report();
  end

  // Whole run needs about 26k cycles
  initial begin
    repeat (80000) @(posedge aclk);
    mismatches++;
    $display("[FAIL] %0t run did not finish", $time);
    final_report();
  end
endmodule : pmw_ctrl_tb_top
`default_nettype wire
